// *** src/rcsr_pkg.sv ***
`default_nettype none
package rcsr_pkg;
    // Register map (word offsets are byte addresses)
    localparam logic [7:0]  ADDR_RESET_CAUSE = 8'h00;
    localparam logic [7:0]  ADDR_SLEEP_STAT  = 8'h04;
    localparam logic [7:0]  ADDR_SLEEP_CMD   = 8'h08;

    // Field positions of reset_cause_register
    localparam int BIT_TRAP     = 15;
    localparam int BIT_ILLOP    = 14;
    localparam int BIT_SWBOR    = 13;
    localparam int BIT_RETSEL   = 12;
    localparam int BIT_DEEP     = 10;
    localparam int BIT_CFGMM    = 9;
    localparam int BIT_PMBIAS   = 8;
    localparam int BIT_EXTPIN   = 7;
    localparam int BIT_SWRST    = 6;
    localparam int BIT_SWWDT    = 5;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG     = 4;
    localparam int BIT_SLEPT    = 3;
    localparam int BIT_IDLED    = 2;
    localparam int BIT_BOR      = 1;
    localparam int BIT_POR      = 0;

    // Writable/implemented bits and value at power-on
    localparam logic [15:0] CAUSE_IMPL_MASK = 16'hf7ff;
    localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;

    // Sleep command register fields
    localparam int CMD_SLEEP = 0;
    localparam int CMD_DEEP  = 1;

    typedef enum logic [1:0] {
        RCSR_MAIN_NORMAL,
        RCSR_MAIN_STANDBY,
        RCSR_MAIN_OFF
    } rcsr_main_e;

    typedef struct packed {
        logic ext_pin;
        logic sw_reset;
        logic wdt_timeout;
        logic brownout;
        logic trap_conflict;
        logic illegal_op;
        logic config_mismatch;
    } rcsr_cause_s;

    typedef struct packed {
        rcsr_main_e main_mode;
        logic       ret_enable;
        logic       ret_supplies;
    } rcsr_supply_s;
endpackage : rcsr_pkg
`default_nettype wire

// *** src/rcsr_ctl.sv ***
// Implementation choices: the Wishbone register port and the address map.
`default_nettype none
// Summary of operation
// - Master-clear pin reset sets bit 7 flag
// - Config 0, select 0, bias 1: main normal
// - Config 0, select 0, bias 0: main standby
// - Config 0, select 1, bias 0: main off, retention on
// - Config 1 ignores select; retention always disabled
// - Config 1, bias 0: main standby in sleep
// - Deep sleep turns off both regulators
// - Deep sleep retains nothing; wake restarts fully
// - Run mode: retention never supplies core
module rcsr_ctl (
    input  wire logic                  clk,          // 125 MHz clock
    input  wire logic                  sys_rst,      // Power-on reset
    input  wire logic                  wb_cyc_i,     // Wishbone cycle
    input  wire logic                  wb_stb_i,     // Wishbone strobe
    input  wire logic                  wb_we_i,      // Write enable
    input  wire logic [7:0]            wb_adr_i,     // Byte address
    input  wire logic [3:0]            wb_sel_i,     // Byte lanes
    input  wire logic [31:0]           wb_dat_i,     // Write data
    output logic      [31:0]           wb_dat_o,     // Read data
    output logic                       wb_ack_o,     // Acknowledge
    input  wire rcsr_pkg::rcsr_cause_s reset_event,  // Reset cause pulses
    input  wire logic                  retention_regulator_config_disable, // Config bit
    input  wire logic                  wake_event,   // Leave sleep
    output logic                       sleep_active, // Core is asleep
    output logic                       deep_active,  // Deep sleep entered
    output rcsr_pkg::rcsr_supply_s     supply,       // Regulator controls
    output logic                       restart_req   // Full restart on deep-sleep wake
);
    logic [15:0]       cause_ff;
    logic [15:0]       nxt_cause;
    logic              ack_ff;
    logic [31:0]       rdat_ff;
    logic              sleep_ff;
    logic              deep_ff;
    logic              restart_ff;
    rcsr_pkg::rcsr_supply_s supply_ff;
    rcsr_pkg::rcsr_supply_s nxt_supply;

    wire        req       = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire        wr        = req & wb_we_i;
    wire        sel_cause = wb_adr_i == rcsr_pkg::ADDR_RESET_CAUSE;
    wire        sel_stat  = wb_adr_i == rcsr_pkg::ADDR_SLEEP_STAT;
    wire        sel_cmd   = wb_adr_i == rcsr_pkg::ADDR_SLEEP_CMD;
    wire        wr_cause  = wr & sel_cause;
    wire        wr_cmd    = wr & sel_cmd & wb_sel_i[0];
    wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
                            & rcsr_pkg::CAUSE_IMPL_MASK;
    wire        go_sleep  = wr_cmd & wb_dat_i[rcsr_pkg::CMD_SLEEP];
    wire        go_deep   = wr_cmd & wb_dat_i[rcsr_pkg::CMD_DEEP];
    wire        cfg_dis   = retention_regulator_config_disable;
    wire        ret_sel   = cause_ff[rcsr_pkg::BIT_RETSEL];
    wire        pm_bias   = cause_ff[rcsr_pkg::BIT_PMBIAS];

    wire [15:0] hw_set = {
        reset_event.trap_conflict, reset_event.illegal_op, 1'b0, 1'b0,
        1'b0, go_deep, reset_event.config_mismatch, 1'b0,
        reset_event.ext_pin,
        reset_event.sw_reset, 1'b0, reset_event.wdt_timeout,
        go_sleep & ~go_deep, 1'b0, reset_event.brownout, 1'b0};

    // Writes only store values; hardware set wins over clear
    always_comb begin
        nxt_cause = cause_ff;
        if (wr_cause) begin
            nxt_cause = (cause_ff & ~lane_mask)
                        | (wb_dat_i[15:0] & lane_mask);
        end
        nxt_cause = nxt_cause | hw_set;
    end

    // Regulator selection
    always_comb begin
        nxt_supply.ret_supplies = 1'b0;
        nxt_supply.ret_enable   = ~cfg_dis;
        nxt_supply.main_mode    = rcsr_pkg::RCSR_MAIN_NORMAL;
        if (deep_ff) begin
            nxt_supply.main_mode  = rcsr_pkg::RCSR_MAIN_OFF;
            nxt_supply.ret_enable = 1'b0;
        end else if (sleep_ff) begin
            if (!cfg_dis && ret_sel && !pm_bias) begin
                nxt_supply.main_mode    = rcsr_pkg::RCSR_MAIN_OFF;
                nxt_supply.ret_supplies = 1'b1;
            end else if (!pm_bias) begin
                nxt_supply.main_mode = rcsr_pkg::RCSR_MAIN_STANDBY;
            end else begin
                nxt_supply.main_mode = rcsr_pkg::RCSR_MAIN_NORMAL;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause_ff <= rcsr_pkg::CAUSE_POR_VALUE;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_ff   <= 1'b0;
            deep_ff    <= 1'b0;
            restart_ff <= 1'b0;
        end else if (wake_event && (sleep_ff || deep_ff)) begin
            sleep_ff   <= 1'b0;
            deep_ff    <= 1'b0;
            restart_ff <= deep_ff;
        end else begin
            sleep_ff   <= sleep_ff | go_sleep | go_deep;
            deep_ff    <= deep_ff | go_deep;
            restart_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            supply_ff <= '{rcsr_pkg::RCSR_MAIN_NORMAL, 1'b0, 1'b0};
        end else begin
            supply_ff <= nxt_supply;
        end
    end

    wire [31:0] rd_mux =
        sel_cause ? {16'h0000, cause_ff & rcsr_pkg::CAUSE_IMPL_MASK} :
        sel_stat  ? {26'h0, supply_ff.main_mode, supply_ff.ret_enable,
                     supply_ff.ret_supplies, deep_ff, sleep_ff} :
        32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff  <= req;
            rdat_ff <= rd_mux;
        end
    end

    assign wb_ack_o     = ack_ff;
    assign wb_dat_o     = rdat_ff;
    assign sleep_active = sleep_ff;
    assign deep_active  = deep_ff;
    assign supply       = supply_ff;
    assign restart_req  = restart_ff;
endmodule : rcsr_ctl
`default_nettype wire

// *** dv/rcsr_chk.sv ***
`default_nettype none
module rcsr_chk (
    input wire logic                   clk,          // Clock
    input wire logic                   sys_rst,      // Reset
    input wire logic                   wb_cyc_i,     // Cycle
    input wire logic                   wb_stb_i,     // Strobe
    input wire logic                   wb_ack_o,     // Ack
    input wire logic                   retention_regulator_config_disable, // Cfg
    input wire logic                   sleep_active, // Sleep
    input wire logic                   deep_active,  // Deep
    input wire rcsr_pkg::rcsr_supply_s supply,       // Regulators
    input wire logic                   restart_req   // Restart
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    chk_ack_next:
        assert property (s_req |=> wb_ack_o) else $error("ack missing");
    chk_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    chk_deep_off:
        assert property ($rose(deep_active) |-> ##[0:1] (!supply.ret_enable
            && supply.main_mode == rcsr_pkg::RCSR_MAIN_OFF))
        else $error("deep sleep regulators on");
    chk_cfg_ret_off:
        assert property ($past(retention_regulator_config_disable)
            |-> !supply.ret_enable) else $error("retention enabled");
    chk_ret_only:
        assert property (supply.ret_supplies |-> supply.ret_enable
            && supply.main_mode == rcsr_pkg::RCSR_MAIN_OFF)
        else $error("retention path wrong");
    chk_run_core:
        assert property (!sleep_active && !$past(sleep_active) |->
            !supply.ret_supplies
            && supply.main_mode == rcsr_pkg::RCSR_MAIN_NORMAL)
        else $error("run supply wrong");
    chk_restart_wake:
        assert property (restart_req |-> $past(deep_active) ##1 !restart_req)
        else $error("restart pulse wrong");
    chk_deep_sleeps:
        assert property (deep_active |-> sleep_active)
        else $error("deep without sleep");
endmodule : rcsr_chk
`default_nettype wire

// *** dv/tb_top.sv ***
`default_nettype none
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h", $time, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i;
    logic                   wb_ack_o, wake_event, sleep_active;
    logic                   deep_active, restart_req;
    logic                   retention_regulator_config_disable;
    logic [3:0]             wb_sel_i;
    logic [7:0]             wb_adr_i;
    logic [31:0]            wb_dat_i, wb_dat_o, q;
    rcsr_pkg::rcsr_cause_s  reset_event;
    rcsr_pkg::rcsr_supply_s supply;
    int                     failures, checks;
    rcsr_ctl i_dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reset_event,
        .retention_regulator_config_disable, .wake_event, .sleep_active,
        .deep_active, .supply, .restart_req);
    task automatic end_sim;
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic wait_on(input bit fail);
        if (fail) begin
            failures++;
            end_sim;
        end
    endtask : wait_on
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        n = 0;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        wait_on(n >= 20);
    endtask : wb
    task automatic t_cause;
        wb(1'b0, 8'h00, 32'h0, q); `CMP(q, 32'h0000_0003)
        reset_event.ext_pin <= 1'b1;
        @(posedge clk) reset_event.ext_pin <= 1'b0;
        wb(1'b0, 8'h00, 32'h0, q); `CMP(q, 32'h0000_0083)
        reset_event <= '1;
        @(posedge clk) reset_event <= '0;
        wb(1'b0, 8'h00, 32'h0, q); `CMP(q, 32'h0000_c2d3)
        wb(1'b1, 8'h00, 32'h0000_ffff, q);
        wb(1'b0, 8'h00, 32'h0, q); `CMP(q, 32'h0000_f7ff)
        `CMP({restart_req, sleep_active}, 2'h0)
        wb(1'b0, 8'h0c, 32'h0, q); `CMP(q, 32'h0)
    endtask : t_cause
    task automatic t_modes;
        logic [2:0] c;
        logic [1:0] m;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            retention_regulator_config_disable <= c[2];
            wb(1'b1, 8'h00, {19'h0, c[1], 3'h0, c[0], 8'h00}, q);
            wb(1'b1, 8'h08, 32'h1, q);
            m = (!c[2] && c[1] && !c[0]) ? 2'h2 : {1'b0, !c[0]};
            wb(1'b0, 8'h04, 32'h0, q);
            `CMP(q[5:0], {m, !c[2], m[1], 2'h1})
            `CMP(supply, {m, !c[2], m[1]})
            wake_event <= 1'b1;
            @(posedge clk) wake_event <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : t_modes
    task automatic t_deep;
        int n;
        retention_regulator_config_disable <= 1'b0;
        wb(1'b1, 8'h08, 32'h2, q);
        wb(1'b0, 8'h04, 32'h0, q); `CMP(q[5:0], 6'h23)
        `CMP({deep_active, sleep_active, supply}, 6'h38)
        wake_event <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (restart_req !== 1'b1 && n < 20);
        wake_event <= 1'b0;
        wait_on(n >= 20);
        wb(1'b0, 8'h00, 32'h0, q); `CMP(q[10], 1'b1)
    endtask : t_deep
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {sys_rst, wb_sel_i, failures, checks} = {1'b1, 4'h3, 64'h0};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {reset_event, wake_event, retention_regulator_config_disable} = '0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_cause;
        t_modes;
        t_deep;
        end_sim;
    end
endmodule : tb_top
bind rcsr_ctl rcsr_chk i_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .retention_regulator_config_disable, .sleep_active,
    .deep_active, .supply, .restart_req);
`default_nettype wire
